//--- core/dss_status_word.v
/*
 * drive state machine and 16-bit status word generator for a drive profile
 * state diagram, including start-up sequencing for three power arrangements.
 * assumes the control word arrives from fieldbus logic on mclk; supply,
 * stop key and fault cause are pins, synchronised here.
 */
`timescale 1ns/1ps
`include "dss_defs.vh"

// Functional notes
// - ready 21h, switched-on 23h, enabled 27h masked
// - disabled 40h, quickstop 07h, fault 08h/28h
// - bit 4 shows power stage supply
// - bit 11 set while reference outside limits
// - bit 15 direction, bit 14 stop key
// - single supply: enable goes through switched-on
// - separate stage supply absent in switched-on timeout: fault
// - contactor closes on accepted switch-on
// - separate stage reaches ready without supply
// - fault cleared on bit 7 rise, cause gone
module dss_status_word #(
    parameter [31:0] MAINS_TO_CYC = `DSS_MAINS_TO_CYC
) (
    input wire mclk,
    input wire rst_n,
    input wire [15:0] ctrl_word,
    input wire [1:0] pwr_mode,
    input wire supply_pin,
    input wire fault_cause_pin,
    input wire stop_key_pin,
    input wire ref_out_of_limits,
    input wire dir_reverse,
    input wire ref_reached,
    input wire warning_active,
    input wire fieldbus_remote,
    output reg [15:0] drive_state_report,
    output reg contactor_close,
    output reg no_mains_display,
    output reg contactor_fault
);

// ==========================================================================
// state codes
localparam [2:0] ST_NRDY = 3'h0;
localparam [2:0] ST_SOD = 3'h1;
localparam [2:0] ST_RDY = 3'h2;
localparam [2:0] ST_SWON = 3'h3;
localparam [2:0] ST_OPEN = 3'h4;
localparam [2:0] ST_QSA = 3'h5;
localparam [2:0] ST_FLT = 3'h6;

// ==========================================================================
// pin synchronisers, three stages, change counts when stages 2 and 3 agree
reg [2:0] sup_s_r, flt_s_r, key_s_r;
reg sup_r, flt_r, key_r;
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        sup_s_r <= 3'h0;
        flt_s_r <= 3'h0;
        key_s_r <= 3'h0;
        sup_r <= 1'b0;
        flt_r <= 1'b0;
        key_r <= 1'b0;
    end else begin
        sup_s_r <= {sup_s_r[1:0], supply_pin};
        flt_s_r <= {flt_s_r[1:0], fault_cause_pin};
        key_s_r <= {key_s_r[1:0], stop_key_pin};
        if (sup_s_r[1] == sup_s_r[2]) sup_r <= sup_s_r[2];
        if (flt_s_r[1] == flt_s_r[2]) flt_r <= flt_s_r[2];
        if (key_s_r[1] == key_s_r[2]) key_r <= key_s_r[2];
    end
end

// ==========================================================================
// command decode
wire [3:0] cmd = ctrl_word[3:0];
wire is_shut = (cmd & 4'h7) == `DSS_CMD_SHUT;
// switch-on needs bit 3 low, otherwise the code reads as enable
wire is_swon = (cmd & 4'h7) == `DSS_CMD_SWON & ~cmd[3];
wire is_enop = cmd == `DSS_CMD_ENOP;
wire dis_volt = ~ctrl_word[`DSS_CW_EV];
wire qstop = ctrl_word[`DSS_CW_EV] & ~ctrl_word[`DSS_CW_QS];
reg frst_prev_r;
wire frst_rise = ctrl_word[`DSS_CW_FRST] & ~frst_prev_r;

// ==========================================================================
// state machine
reg [2:0] state_r, state_nxt;
reg qs_fault_r, qs_fault_nxt;
reg [31:0] to_cnt_r;
wire to_hit = to_cnt_r >= MAINS_TO_CYC;
wire sep = pwr_mode != `DSS_PWR_SINGLE;
wire sup_ok = sup_r | (pwr_mode == `DSS_PWR_CONTACTOR);
// timeout cause stands while the stage supply is still missing; with a
// drive-controlled contactor the supply only returns after switch-on,
// so there the cause counts as gone once the fault is taken
wire to_cause = contactor_fault && !sup_r && (pwr_mode == `DSS_PWR_SEPARATE);

always @* begin
    state_nxt = state_r;
    qs_fault_nxt = qs_fault_r;
    case (state_r)
        ST_NRDY: begin
            state_nxt = ST_SOD;
        end
        ST_SOD: begin
            // separate stage needs no supply to reach ready
            if (is_shut && (sep || sup_r)) state_nxt = ST_RDY;
        end
        ST_RDY: begin
            if (dis_volt || qstop) state_nxt = ST_SOD;
            else if (is_enop && !sep) state_nxt = ST_SWON;
            else if (is_swon || is_enop) state_nxt = ST_SWON;
        end
        ST_SWON: begin
            if (dis_volt || qstop) state_nxt = ST_SOD;
            else if (is_shut) state_nxt = ST_RDY;
            else if (to_hit) begin
                state_nxt = ST_FLT;
                qs_fault_nxt = 1'b0;
            end else if (is_enop && sup_ok) state_nxt = ST_OPEN;
        end
        ST_OPEN: begin
            if (dis_volt) state_nxt = ST_SOD;
            else if (qstop) state_nxt = ST_QSA;
            else if (is_shut) state_nxt = ST_RDY;
            else if (is_swon) state_nxt = ST_SWON;
            else if (flt_r) begin
                state_nxt = ST_FLT;
                qs_fault_nxt = 1'b0;
            end
        end
        ST_QSA: begin
            if (flt_r) begin
                state_nxt = ST_FLT;
                qs_fault_nxt = 1'b1;
            end else if (dis_volt) state_nxt = ST_SOD;
        end
        ST_FLT: begin
            // fresh reset edge and no cause left, else stay in fault
            if (frst_rise && !flt_r && !to_cause) state_nxt = ST_SOD;
        end
        default: state_nxt = ST_NRDY;
    endcase
    if (flt_r && state_r != ST_FLT && state_r != ST_QSA && state_r != ST_NRDY) begin
        state_nxt = ST_FLT;
        qs_fault_nxt = 1'b0;
    end
end

// ==========================================================================
// state, timeout counter and contactor
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        state_r <= ST_NRDY;
        qs_fault_r <= 1'b0;
        frst_prev_r <= 1'b0;
        to_cnt_r <= 32'h0;
        contactor_close <= 1'b0;
        contactor_fault <= 1'b0;
        no_mains_display <= 1'b0;
    end else begin
        state_r <= state_nxt;
        qs_fault_r <= qs_fault_nxt;
        frst_prev_r <= ctrl_word[`DSS_CW_FRST];
        // supply wait timer only in switched-on without supply
        if (state_r == ST_SWON && sep && !sup_r && !to_hit)
            to_cnt_r <= to_cnt_r + 32'h1;
        else if (state_r != ST_SWON || sup_r)
            to_cnt_r <= 32'h0;
        // counter holds at the limit until the state moves on
        // sticky until reset from fault; set wins over clear
        if (state_r == ST_SWON && state_nxt == ST_FLT && to_hit)
            contactor_fault <= 1'b1;
        else if (state_nxt == ST_SOD && state_r == ST_FLT)
            contactor_fault <= 1'b0;
        if (pwr_mode == `DSS_PWR_CONTACTOR)
            contactor_close <= (state_nxt == ST_SWON || state_nxt == ST_OPEN ||
                                state_nxt == ST_QSA);
        else
            contactor_close <= 1'b0;
        no_mains_display <= (state_nxt == ST_RDY) && !sup_r;
    end
end

// ==========================================================================
// status word assembly
reg [15:0] sw_nxt;
always @* begin
    sw_nxt = 16'h0000;
    case (state_nxt)
        ST_SOD: sw_nxt[6:0] = 7'h40;
        ST_RDY: sw_nxt[6:0] = 7'h21;
        ST_SWON: sw_nxt[6:0] = 7'h23;
        ST_OPEN: sw_nxt[6:0] = 7'h27;
        ST_QSA: sw_nxt[6:0] = 7'h07;
        ST_FLT: sw_nxt[6:0] = qs_fault_nxt ? 7'h28 : 7'h08;
        default: sw_nxt[6:0] = 7'h00;
    endcase
    // side bits follow their sources in every state
    sw_nxt[`DSS_B_VOLT] = sup_r;
    sw_nxt[`DSS_B_WARN] = warning_active;
    sw_nxt[`DSS_B_REMOTE] = fieldbus_remote;
    sw_nxt[`DSS_B_TGT] = ref_reached;
    sw_nxt[`DSS_B_LIMIT] = ref_out_of_limits;
    sw_nxt[`DSS_B_STOPKEY] = key_r;
    sw_nxt[`DSS_B_DIR] = dir_reverse;
end

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) drive_state_report <= 16'h0000;
    else drive_state_report <= sw_nxt;
end

endmodule

//--- pkg/dss_defs.vh
/*
 * constants of the drive state status word block: bit positions, power arrangements,
 * command encodings and timing counts.
 * assumes inclusion by bare name from core files; definitions only.
 */
`ifndef DSS_DEFS_VH
`define DSS_DEFS_VH

// ==========================================================================
// status word bit positions
`define DSS_B_RDY 0
`define DSS_B_SWON 1
`define DSS_B_OPEN 2
`define DSS_B_FLT 3
`define DSS_B_VOLT 4
`define DSS_B_QSN 5
`define DSS_B_SOD 6
`define DSS_B_WARN 7
`define DSS_B_REMOTE 9
`define DSS_B_TGT 10
`define DSS_B_LIMIT 11
`define DSS_B_STOPKEY 14
`define DSS_B_DIR 15

// ==========================================================================
// control word masks and command codes (low four bits)
`define DSS_CMD_MASK 4'hF
`define DSS_CMD_SHUT 4'h6
`define DSS_CMD_SWON 4'h7
`define DSS_CMD_ENOP 4'hF
`define DSS_CMD_ENOP_M 4'hB
`define DSS_CW_FRST 7
`define DSS_CW_QS 2
`define DSS_CW_EV 1

// ==========================================================================
// power arrangements
`define DSS_PWR_SINGLE 2'h0
`define DSS_PWR_SEPARATE 2'h1
`define DSS_PWR_CONTACTOR 2'h2

// ==========================================================================
// timing: contactor supply timeout in ms and clock rate in kHz
`define DSS_MAINS_TO_MS 1000
`define DSS_CLK_KHZ 100000
`define DSS_MAINS_TO_CYC (`DSS_MAINS_TO_MS * `DSS_CLK_KHZ)

`endif

//--- test/dss_master.sv
/* fieldbus master model that issues control word commands.
   assumes the bench calls cmd and shares mclk with the block. */
`timescale 1ns/1ps
// ==========
// master
module dss_master (
    input wire mclk,
    output logic [15:0] ctrl_word
);
    initial ctrl_word = 16'h0000;
    // issue a command just after an edge and hold it
    task automatic cmd(input logic [15:0] v);
        @(posedge mclk);
        ctrl_word <= v;
    endtask
endmodule

//--- test/dss_status_word_chk.sv
/* concurrent checks on the status word block.
   assumes binding to dss_status_word; sees its ports only. */
`timescale 1ns/1ps
// ==========
// checker
module dss_chk (
    input wire mclk,
    input wire rst_n,
    input wire [15:0] ctrl_word,
    input wire [1:0] pwr_mode,
    input wire fault_cause_pin,
    input wire ref_out_of_limits,
    input wire dir_reverse,
    input wire [15:0] drive_state_report,
    input wire contactor_close,
    input wire no_mains_display
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // masked state code
    wire [15:0] m = drive_state_report & 16'h006F;
    wire flt = m == 16'h0008 || m == 16'h0028;
    a_rsvd_zero: assert property (drive_state_report[13:12] == 2'h0 && !drive_state_report[8])
        else $error("reserved status bit set");
    a_limit_bit: assert property ($past(rst_n) |-> drive_state_report[11] == $past(ref_out_of_limits))
        else $error("limit bit wrong");
    a_dir_bit: assert property ($past(rst_n) |-> drive_state_report[15] == $past(dir_reverse))
        else $error("direction bit wrong");
    a_no_mains: assert property (no_mains_display == (m == 16'h0021 && !drive_state_report[4]))
        else $error("no mains flag wrong");
    a_contactor_mode: assert property (contactor_close |-> pwr_mode == 2'h2)
        else $error("contactor closed outside mode 2");
    a_legal_code: assert property (m inside {16'h0000, 16'h0040, 16'h0021, 16'h0023,
        16'h0027, 16'h0007, 16'h0008, 16'h0028}) else $error("illegal state code");
    a_single_enop: assert property (pwr_mode == 2'h0 && m == 16'h0023 && ctrl_word[3:0] == 4'hF
        && !fault_cause_pin |=> m == 16'h0027) else $error("enable not reached");
    a_sep_shut: assert property (pwr_mode == 2'h1 && m == 16'h0040 && ctrl_word[3:0] == 4'h6
        && !fault_cause_pin |=> m == 16'h0021) else $error("shutdown not taken");
    a_fault_hold: assert property (flt && !(ctrl_word[7] && !$past(ctrl_word[7])) |=> flt)
        else $error("fault left without reset edge");
    c_enabled: cover property (m == 16'h0027);
    c_qs_fault: cover property (m == 16'h0028);
    c_close: cover property (contactor_close);
endmodule
bind dss_status_word dss_chk u_chk (.mclk, .rst_n, .ctrl_word, .pwr_mode, .fault_cause_pin,
    .ref_out_of_limits, .dir_reverse, .drive_state_report, .contactor_close, .no_mains_display);

//--- test/tb_dss_status_word.sv
/* self-checking bench of the status word block.
   assumes the master model and checker are compiled first. */
`timescale 1ns/1ps
// ==========
// bench
module tb_dss_status_word;
    logic mclk = 0, rst_n = 0, sup = 0, flt = 0;
    logic [1:0] mode = 2'h1;
    logic [5:0] aux = 6'h00;
    wire [15:0] cw, rep;
    wire cc, nm, cf;
    int errors = 0, num_checks = 0, cyc = 0;
    dss_master u_mst (.mclk, .ctrl_word(cw));
    dss_status_word #(.MAINS_TO_CYC(32'd20)) u_dut (.mclk, .rst_n, .ctrl_word(cw),
        .pwr_mode(mode), .supply_pin(sup), .fault_cause_pin(flt), .stop_key_pin(aux[4]),
        .ref_out_of_limits(aux[3]), .dir_reverse(aux[5]), .ref_reached(aux[2]),
        .warning_active(aux[0]), .fieldbus_remote(aux[1]), .drive_state_report(rep),
        .contactor_close(cc), .no_mains_display(nm), .contactor_fault(cf));
    initial forever #5 mclk = ~mclk;
    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 2000) begin
            errors++;
            test_done();
        end
    end
    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", n, exp, got);
        end
    endtask
    // poll the masked state code for a bounded time
    task automatic wst(input logic [15:0] exp, input int n);
        for (int i = 0; i < n && (rep & 16'h006F) !== exp; i++) @(posedge mclk) #1;
        chk("state", rep & 16'h006F, exp);
    endtask
    task automatic start(input logic [1:0] md, input logic s);
        // idle the control word at the edge that applies reset
        u_mst.cmd(16'h0000);
        rst_n <= 1'b0;
        mode <= md;
        sup <= s;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        wst(16'h0040, 4);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        start(2'h1, 1'b0);
        // side bits follow their inputs, alternate bits each pass
        @(posedge mclk) aux <= 6'h15;
        repeat (6) @(posedge mclk) #1;
        chk("aux_a", rep & 16'hCE80, 16'h4480);
        @(posedge mclk) aux <= 6'h2A;
        repeat (6) @(posedge mclk) #1;
        chk("aux_b", rep & 16'hCE80, 16'h8A00);
        @(posedge mclk) aux <= 6'h00;
        repeat (6) @(posedge mclk) #1;
        chk("aux0", rep & 16'hCE80, 16'h0000);
        // separate stage without supply, then contactor timeout
        u_mst.cmd(16'h0006);
        wst(16'h0021, 8);
        chk("nomains", nm, 16'h0001);
        u_mst.cmd(16'h0007);
        wst(16'h0023, 8);
        chk("open_sep", cc, 16'h0000);
        wst(16'h0008, 60);
        chk("cfault", cf, 16'h0001);
        @(posedge mclk) sup <= 1'b1;
        u_mst.cmd(16'h0000);
        repeat (6) @(posedge mclk);
        u_mst.cmd(16'h0080);
        wst(16'h0040, 8);
        chk("cfclr", cf, 16'h0000);
        // full start with supply, quick stop, then a fault
        u_mst.cmd(16'h0006);
        wst(16'h0021, 8);
        chk("ready", rep, 16'h0031);
        u_mst.cmd(16'h0007);
        wst(16'h0023, 8);
        u_mst.cmd(16'h000F);
        wst(16'h0027, 8);
        u_mst.cmd(16'h0002);
        wst(16'h0007, 8);
        @(posedge mclk) flt <= 1'b1;
        wst(16'h0028, 10);
        @(posedge mclk) flt <= 1'b0;
        repeat (6) @(posedge mclk);
        u_mst.cmd(16'h0080);
        wst(16'h0040, 8);
        // drive-controlled contactor
        start(2'h2, 1'b0);
        u_mst.cmd(16'h0006);
        wst(16'h0021, 8);
        chk("open_rdy", cc, 16'h0000);
        u_mst.cmd(16'h0007);
        wst(16'h0023, 8);
        chk("close", cc, 16'h0001);
        // single supply: enable from ready through switched-on
        start(2'h0, 1'b1);
        repeat (6) @(posedge mclk);
        u_mst.cmd(16'h0006);
        wst(16'h0021, 8);
        u_mst.cmd(16'h000F);
        wst(16'h0027, 4);
        // reference sent only once enabled; reached flag follows
        @(posedge mclk) aux <= 6'h04;
        repeat (2) @(posedge mclk) #1;
        chk("reached", rep & 16'hCE80, 16'h0400);
        test_done();
    end
endmodule
